//--- rtl/capture_timer.sv
// Capture timer: event handling, flags, run status, debug halt and 16-bit counter access.
//
// Overview of operation
// - Periodic and 8-bit PWM modes ignore both event edges.
// - Time-out mode: selected edge starts counter, the other edge stops it.
// - Capture mode: selected edge loads capture register and sets flag.
// - Frequency mode: selected edge captures, clears, restarts and sets flag.
// - Pulse-width mode: one edge restarts counter, opposite edge captures and flags.
// - Combined mode: restart, capture on opposite edge, stop on second edge.
// - Combined mode sets flag only at the stopping second edge.
// - Single-shot: selected edge starts counter, flag at top value.
// - Periodic and time-out modes set flag when counter reaches top.
// - 8-bit PWM sets flag when counter reaches compare high byte.
// - Events act only while capture event input enable is 1.
// - Interrupt enable bit 0 gates the capture interrupt.
// - Flag clears by writing 1, or reading capture in capture modes.
// - Run status reads 1 while counting; it is read-only.
// - Debug run 0 halts block in debug break; 1 keeps running.
// - One shared byte latch serves all 16-bit registers.
// - Counter low byte at base, high at base plus one, resets zero.
// - Bus write to the counter wins over internal count update.
// - Three-bit count mode field selects one of eight modes.
// - Interrupt request stands while flag and enable are both set.
`timescale 1ns/1ns
module capture_timer
	import capture_timer_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       reset_n,
	// Register port.
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rdata,
	// Capture event and debug break.
	input  wire logic       capture_event,
	input  wire logic       debug_break,
	// Interrupt request.
	output logic            capture_irq
);
	typedef struct packed {
		logic [7:0]  rdata;
		logic        irq;
		logic        enable;
		logic [2:0]  mode;
		logic        edge_sel;
		logic        capture_ei;
		logic        int_en;
		logic        flag;
		logic        running;
		logic        debug_run;
		logic [7:0]  latch;
		logic [15:0] count;
		logic [15:0] compare;
		logic        freq_pw_armed;
		logic        freq_pw_done;
	} timer_s;

	timer_s state_ff;
	timer_s nxt_state;
	logic   rst_meta_ff;
	logic   rst_sync_ff;
	logic   rise;
	logic   fall;
	logic   active;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	assign active = state_ff.enable & (state_ff.debug_run | ~debug_break);

	event_edge_detect u_edge (
		.clk      (clk),
		.rst_n    (rst_sync_ff),
		.event_in (capture_event),
		.accept   (active & state_ff.capture_ei),
		.rise     (rise),
		.fall     (fall)
	);

	function automatic logic is_capture_mode(input logic [2:0] m);
		return (m == mode_capture) || (m == mode_frequency) ||
			(m == mode_pulse) || (m == mode_freq_pw);
	endfunction

	always_comb begin
		logic sel;
		logic other;
		logic set_flag;
		logic at_top;
		logic do_capture;
		logic do_restart;
		logic [15:0] top;
		sel        = state_ff.edge_sel ? fall : rise;
		other      = state_ff.edge_sel ? rise : fall;
		set_flag   = 1'b0;
		at_top     = 1'b0;
		do_capture = 1'b0;
		do_restart = 1'b0;
		top        = state_ff.compare;
		nxt_state  = state_ff;
		// Read data stand for one cycle only; every other cycle shows zero.
		nxt_state.rdata = 8'h00;

		// top is compare high byte in PWM
		if (state_ff.mode == mode_pwm8) begin
			top = {8'h00, state_ff.compare[15:8]};
		end
		// A captured value is no top, so capture modes count through the full range.
		at_top = state_ff.running && !is_capture_mode(state_ff.mode) &&
			(state_ff.count == top);

		if (active && state_ff.running) begin
			if (at_top) begin
				nxt_state.count = count_reset;
			end else begin
				nxt_state.count = state_ff.count + 16'h0001;
			end
		end

		case (count_mode_e'(state_ff.mode))
			mode_periodic: begin
				nxt_state.running = state_ff.enable;
				set_flag          = active & at_top;
			end
			mode_pwm8: begin
				nxt_state.running = state_ff.enable;
				set_flag          = active & at_top;
			end
			mode_timeout: begin
				if (sel) begin
					nxt_state.running = 1'b1;
				end else if (other) begin
					nxt_state.running = 1'b0;
				end
				set_flag = active & at_top;
			end
			mode_capture: begin
				nxt_state.running = state_ff.enable;
				do_capture = sel;
			end
			mode_frequency: begin
				nxt_state.running = state_ff.enable;
				do_capture = sel;
				do_restart = sel;
			end
			mode_pulse: begin
				nxt_state.running = state_ff.enable;
				do_restart = sel;
				do_capture = other;
			end
			mode_freq_pw: begin
				if (sel && !state_ff.freq_pw_armed) begin
					do_restart              = 1'b1;
					nxt_state.running       = 1'b1;
					nxt_state.freq_pw_armed = 1'b1;
					nxt_state.freq_pw_done  = 1'b0;
				end else if (other && state_ff.freq_pw_armed && !state_ff.freq_pw_done) begin
					nxt_state.compare      = state_ff.count;
					nxt_state.freq_pw_done = 1'b1;
				end else if (sel && state_ff.freq_pw_done) begin
					nxt_state.running       = 1'b0;
					nxt_state.freq_pw_armed = 1'b0;
					nxt_state.freq_pw_done  = 1'b0;
					set_flag                = 1'b1;
				end
			end
			mode_single: begin
				// start on edge, flag at top
				if (sel) begin
					nxt_state.running = 1'b1;
				end else if (active && at_top) begin
					nxt_state.running = 1'b0;
					set_flag          = 1'b1;
				end
			end
			default: begin
				nxt_state.running = 1'b0;
			end
		endcase

		if (do_capture) begin
			nxt_state.compare = state_ff.count;
			set_flag          = 1'b1;
		end
		if (do_restart) begin
			nxt_state.count = count_reset;
		end
		if (!state_ff.enable) begin
			nxt_state.running = 1'b0;
		end
		// A mode change abandons a half-done combined measurement.
		if (state_ff.mode != mode_freq_pw) begin
			nxt_state.freq_pw_armed = 1'b0;
			nxt_state.freq_pw_done  = 1'b0;
		end

		// Register reads; a capture read may clear the flag.
		if (rd_en) begin
			case (addr)
				ctrl_a_off:           nxt_state.rdata[enable_bit] = state_ff.enable;
				ctrl_b_off:           nxt_state.rdata[2:0] = state_ff.mode;
				event_control_off: begin
					nxt_state.rdata[edge_bit]       = state_ff.edge_sel;
					nxt_state.rdata[capture_ei_bit] = state_ff.capture_ei;
				end
				interrupt_enable_off: nxt_state.rdata[capture_flag_bit] = state_ff.int_en;
				interrupt_flags_off:  nxt_state.rdata[capture_flag_bit] = state_ff.flag;
				counter_status_off:   nxt_state.rdata[run_bit] = state_ff.running;
				debug_control_off:    nxt_state.rdata[debug_run_bit_pos] = state_ff.debug_run;
				shared_latch_off:     nxt_state.rdata = state_ff.latch;
				counter_low_off: begin
					nxt_state.rdata = state_ff.count[7:0];
					nxt_state.latch = state_ff.count[15:8];
				end
				counter_high_off:     nxt_state.rdata = state_ff.latch;
				compare_low_off: begin
					nxt_state.rdata = state_ff.compare[7:0];
					nxt_state.latch = state_ff.compare[15:8];
					if (is_capture_mode(state_ff.mode)) begin
						nxt_state.flag = 1'b0;
					end
				end
				compare_high_off:     nxt_state.rdata = state_ff.latch;
				default:              nxt_state.rdata = 8'h00;
			endcase
		end

		if (wr_en) begin
			case (addr)
				ctrl_a_off:           nxt_state.enable = wdata[enable_bit];
				ctrl_b_off:           nxt_state.mode = wdata[count_mode_lsb +: 3];
				event_control_off: begin
					nxt_state.edge_sel   = wdata[edge_bit];
					nxt_state.capture_ei = wdata[capture_ei_bit];
				end
				interrupt_enable_off: nxt_state.int_en = wdata[capture_flag_bit];
				interrupt_flags_off: begin
					if (wdata[capture_flag_bit]) begin
						nxt_state.flag = 1'b0;
					end
				end
				debug_control_off:    nxt_state.debug_run = wdata[debug_run_bit_pos];
				shared_latch_off:     nxt_state.latch = wdata;
				counter_low_off:      nxt_state.latch = wdata;
				counter_high_off:     nxt_state.count = {wdata, state_ff.latch};
				compare_low_off:      nxt_state.latch = wdata;
				compare_high_off:     nxt_state.compare = {wdata, state_ff.latch};
				default: begin
				end
			endcase
		end

		// Set wins over a clear in the same cycle.
		if (set_flag) begin
			nxt_state.flag = 1'b1;
		end

		nxt_state.irq = nxt_state.flag & nxt_state.int_en;
	end

	always_ff @(posedge clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign rdata       = state_ff.rdata;
	assign capture_irq = state_ff.irq;
endmodule

//--- rtl/capture_timer_pkg.sv
// Package with register map, field positions, reset values and mode codes of the capture timer.
package capture_timer_pkg;
	localparam logic [3:0] ctrl_a_off           = 4'h0;
	localparam logic [3:0] ctrl_b_off           = 4'h1;
	localparam logic [3:0] event_control_off    = 4'h4;
	localparam logic [3:0] interrupt_enable_off = 4'h5;
	localparam logic [3:0] interrupt_flags_off  = 4'h6;
	localparam logic [3:0] counter_status_off   = 4'h7;
	localparam logic [3:0] debug_control_off    = 4'h8;
	localparam logic [3:0] shared_latch_off     = 4'h9;
	localparam logic [3:0] counter_low_off      = 4'ha;
	localparam logic [3:0] counter_high_off     = 4'hb;
	localparam logic [3:0] compare_low_off      = 4'hc;
	localparam logic [3:0] compare_high_off     = 4'hd;

	localparam int enable_bit        = 0;
	localparam int count_mode_lsb    = 0;
	localparam int capture_ei_bit    = 0;
	localparam int edge_bit          = 4;
	localparam int capture_flag_bit  = 0;
	localparam int run_bit           = 0;
	localparam int debug_run_bit_pos = 0;

	localparam logic [7:0]  reg_reset   = 8'h00;
	localparam logic [15:0] count_reset = 16'h0000;

	typedef enum logic [2:0] {
		mode_periodic  = 3'h0,
		mode_timeout   = 3'h1,
		mode_capture   = 3'h2,
		mode_frequency = 3'h3,
		mode_pulse     = 3'h4,
		mode_freq_pw   = 3'h5,
		mode_single    = 3'h6,
		mode_pwm8      = 3'h7
	} count_mode_e;
endpackage

//--- rtl/event_edge_detect.sv
// Edge detector for the capture event input.
`timescale 1ns/1ns
module event_edge_detect (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst_n,
	// Event level and qualifier.
	input  wire logic event_in,
	input  wire logic accept,
	// Edge pulses.
	output logic      rise,
	output logic      fall
);
	typedef struct packed {
		logic last;
	} edge_s;

	edge_s state_ff;
	edge_s nxt_state;

	always_comb begin
		nxt_state      = state_ff;
		nxt_state.last = event_in;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Level is tracked always, so a halt does not fake an edge on resume.
	assign rise = accept & event_in & ~state_ff.last;
	assign fall = accept & ~event_in & state_ff.last;
endmodule

//--- sim/capture_timer_checker.sv
// Port checker for the capture timer.
`timescale 1ns/1ns
module capture_timer_checker
	import capture_timer_pkg::*;
(
	// Clock and reset.
	input wire logic       clk,
	input wire logic       reset_n,
	// Register port.
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr_en,
	input wire logic       rd_en,
	input wire logic [7:0] rdata,
	// Event, debug and interrupt.
	input wire logic       capture_event,
	input wire logic       debug_break,
	input wire logic       capture_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
		else $error("read data outside its cycle");
	a_unmapped_zero: assert property (rd_en && addr inside {4'h2, 4'h3, 4'he, 4'hf}
		|=> rdata == 8'h00) else $error("unmapped read not zero");
	a_latch_back: assert property (wr_en && addr == shared_latch_off ##1 !wr_en && !rd_en
		##1 rd_en && addr == shared_latch_off |=> rdata == $past(wdata, 3))
		else $error("latch readback differs");
	a_enable_back: assert property (wr_en && addr == interrupt_enable_off ##1 !wr_en
		&& !rd_en ##1 rd_en && addr == interrupt_enable_off |=> rdata[0] == $past(wdata[0], 3))
		else $error("enable readback differs");
	a_irq_off: assert property (wr_en && addr == interrupt_enable_off && !wdata[0]
		|-> ##2 !capture_irq) else $error("irq stays without enable");
	a_irq_has_en: assert property (rd_en && addr == interrupt_enable_off && capture_irq
		&& !$past(wr_en) && !$past(wr_en, 2) |=> rdata[0]) else $error("irq without enable");
	a_irq_has_flag: assert property (rd_en && addr == interrupt_flags_off && capture_irq
		&& !$past(wr_en) && !$past(wr_en, 2) |=> rdata[0]) else $error("irq without flag");
	a_high_bits: assert property (rd_en && addr inside {4'h5, 4'h6, 4'h7, 4'h8}
		|=> rdata[7:1] == 7'h00) else $error("unused bits set");
	c_irq_rise: cover property ($rose(capture_irq));
	c_irq_fall: cover property ($fell(capture_irq));
	c_event_rise: cover property ($rose(capture_event));
endmodule
bind capture_timer capture_timer_checker capture_timer_checker_inst (.clk(clk),
	.reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
	.rdata(rdata), .capture_event(capture_event), .debug_break(debug_break),
	.capture_irq(capture_irq));

//--- sim/event_router.sv
// Event source standing in for the event routing network.
`timescale 1ns/1ns
module event_router (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic reset_n,
	// Requested level and routed event.
	input  wire logic level_req,
	output logic      capture_event
);
	// Routed events change only after a clock edge, so the timer sees them synchronously.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			capture_event <= 1'b0;
		end else begin
			capture_event <= level_req;
		end
	end
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the capture timer.
`timescale 1ns/1ns
module tb_top;
	import capture_timer_pkg::*;
	logic        clk;
	logic        reset_n;
	logic [3:0]  addr;
	logic [7:0]  wdata;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  rdata;
	logic        capture_event;
	logic        debug_break;
	logic        capture_irq;
	logic        level_req;
	logic [7:0]  rv;
	logic [15:0] cv;
	int          error_cnt;
	int          samples_checked;

	capture_timer capture_timer_inst (.clk(clk), .reset_n(reset_n), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.capture_event(capture_event), .debug_break(debug_break), .capture_irq(capture_irq));
	event_router event_router_inst (.clk(clk), .reset_n(reset_n), .level_req(level_req),
		.capture_event(capture_event));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 rv = rdata;
	endtask

	task automatic ev(input logic v);
		@(posedge clk);
		level_req <= v;
		repeat (4) @(posedge clk);
	endtask

	task automatic irq_is(input logic exp, input string msg);
		check({7'h00, capture_irq}, {7'h00, exp}, msg);
	endtask

	// Reading the capture low byte clears the flag in capture modes.
	task automatic clear_cap();
		rd(compare_low_off);
		repeat (2) @(posedge clk);
		irq_is(1'b0, "capture read clear");
	endtask

	// The pulse-width mode flags on the edge after the restart edge, the others on the first.
	function automatic logic exp_flag(input logic [2:0] m, input logic first);
		return (m == mode_pulse) ? !first : first;
	endfunction

	initial begin
		reset_n = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		debug_break = 1'b0;
		level_req = 1'b0;
		error_cnt = 0;
		samples_checked = 0;
		cv = 16'($urandom(32'he363));
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int a = 5; a < 12; a++) begin
			rd(a[3:0]);
			check(rv, reg_reset, "reset value");
		end
		wr(interrupt_enable_off, 8'h01);
		rd(interrupt_enable_off);
		check(rv, 8'h01, "enable readback");
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			cv[7:0] = 8'($urandom);
			wr(shared_latch_off, cv[7:0]);
			rd(shared_latch_off);
			check(rv, cv[7:0], "latch");
			cv = 16'($urandom);
			wr(counter_low_off, cv[7:0]);
			wr(counter_high_off, cv[15:8]);
			rd(counter_low_off);
			check(rv, cv[7:0], "count low");
			rd(counter_high_off);
			check(rv, cv[15:8], "count high");
			rv = 8'($urandom);
			wr({rv[1], rv[1], 1'b1, rv[0]}, rv);
			rd({rv[1], rv[1], 1'b1, rv[0]});
			check(rv, 8'h00, "unmapped");
		end
		wr(counter_status_off, 8'h01);
		rd(counter_status_off);
		check(rv, 8'h00, "status written");
		$display("test registers done");
		wr(ctrl_b_off, 8'h02);
		wr(ctrl_a_off, 8'h01);
		rd(counter_status_off);
		check(rv, 8'h01, "running");
		for (int m = 2; m < 5; m++) begin
			for (int p = 0; p < 2; p++) begin
				wr(event_control_off, 8'h00);
				wr(ctrl_b_off, m[7:0]);
				ev(p[0]);
				wr(event_control_off, {3'h0, p[0], 4'h1});
				ev(!p[0]);
				irq_is(exp_flag(m[2:0], 1'b1), "selected edge");
				if (capture_irq === 1'b1) clear_cap();
				ev(p[0]);
				irq_is(exp_flag(m[2:0], 1'b0), "other edge");
				if (capture_irq === 1'b1) clear_cap();
			end
		end
		wr(ctrl_b_off, 8'h02);
		wr(event_control_off, 8'h00);
		ev(1'b0);
		ev(1'b1);
		irq_is(1'b0, "input disabled");
		wr(event_control_off, 8'h01);
		debug_break <= 1'b1;
		ev(1'b0);
		ev(1'b1);
		irq_is(1'b0, "debug halt");
		wr(debug_control_off, 8'h01);
		ev(1'b0);
		ev(1'b1);
		irq_is(1'b1, "debug run");
		debug_break <= 1'b0;
		clear_cap();
		wr(counter_low_off, 8'h34);
		wr(counter_high_off, 8'h12);
		rd(counter_low_off);
		check(rv, 8'h35, "write beats count");
		wr(ctrl_b_off, 8'h05);
		ev(1'b0);
		ev(1'b1);
		irq_is(1'b0, "combined restart");
		ev(1'b0);
		irq_is(1'b0, "combined capture");
		ev(1'b1);
		irq_is(1'b1, "combined stop");
		clear_cap();
		check(rv, 8'h04, "pulse width");
		rd(counter_status_off);
		check(rv, 8'h00, "combined stopped");
		wr(ctrl_b_off, 8'h06);
		wr(compare_low_off, 8'h08);
		wr(compare_high_off, 8'h00);
		wr(counter_low_off, 8'h00);
		wr(counter_high_off, 8'h00);
		ev(1'b0);
		ev(1'b1);
		rd(counter_status_off);
		check(rv, 8'h01, "single start");
		repeat (8) @(posedge clk);
		irq_is(1'b1, "single top");
		rd(counter_status_off);
		check(rv, 8'h00, "single stopped");
		wr(interrupt_flags_off, 8'h01);
		wr(ctrl_b_off, 8'h01);
		ev(1'b0);
		ev(1'b1);
		rd(counter_status_off);
		check(rv, 8'h01, "timeout start");
		repeat (8) @(posedge clk);
		irq_is(1'b1, "timeout top");
		ev(1'b0);
		rd(counter_status_off);
		check(rv, 8'h00, "timeout stop");
		wr(ctrl_b_off, 8'h07);
		wr(compare_low_off, 8'h08);
		wr(compare_high_off, 8'h06);
		wr(counter_low_off, 8'h00);
		wr(counter_high_off, 8'h00);
		wr(interrupt_flags_off, 8'h01);
		repeat (9) @(posedge clk);
		irq_is(1'b1, "pwm top");
		ev(1'b1);
		ev(1'b0);
		rd(compare_low_off);
		check(rv, 8'h08, "pwm ignores edges");
		rd(counter_status_off);
		check(rv, 8'h01, "pwm keeps running");
		$display("test events done");
		wr(ctrl_a_off, 8'h00);
		wr(interrupt_enable_off, 8'h00);
		wr(interrupt_flags_off, 8'h01);
		wr(counter_low_off, 8'h00);
		wr(counter_high_off, 8'h00);
		wr(compare_low_off, 8'h10);
		wr(compare_high_off, 8'h00);
		wr(ctrl_b_off, 8'h00);
		wr(ctrl_a_off, 8'h01);
		rv = 8'h00;
		for (int i = 0; i < 20 && rv[0] !== 1'b1; i++) rd(interrupt_flags_off);
		check(rv, 8'h01, "top flag");
		irq_is(1'b0, "masked");
		ev(1'b1);
		ev(1'b0);
		rd(compare_low_off);
		check(rv, 8'h10, "periodic ignores edges");
		wr(ctrl_a_off, 8'h00);
		wr(interrupt_flags_off, 8'h00);
		rd(interrupt_flags_off);
		check(rv, 8'h01, "write zero");
		wr(interrupt_enable_off, 8'h01);
		repeat (2) @(posedge clk);
		irq_is(1'b1, "unmasked");
		rd(interrupt_flags_off);
		check(rv, 8'h01, "flag with irq");
		wr(interrupt_flags_off, 8'h01);
		repeat (2) @(posedge clk);
		irq_is(1'b0, "write one");
		$display("test periodic done");
		print_verdict();
	end
endmodule
